/* File: bsa_cfg.svh */
/*
  constants for the bit-slice alu: slice width, register file size, selector codes,
  function group codes and reset values.
  assumes it is included by its bare name from the package and design files.
*/
`ifndef BSA_CFG_SVH
`define BSA_CFG_SVH

// slice geometry
`define BSA_W          2
`define BSA_SEL_W      4
`define BSA_NREG       10

// scratch selector codes above the register file
`define BSA_SEL_T      4'ha
`define BSA_SEL_AC     4'hb

// function group codes
`define BSA_FG_W       3
`define BSA_FG_0       3'h0
`define BSA_FG_1       3'h1
`define BSA_FG_2       3'h2
`define BSA_FG_3       3'h3
`define BSA_FG_4       3'h4
`define BSA_FG_5       3'h5

// register group codes
`define BSA_RG_W       2
`define BSA_RG_I       2'h1
`define BSA_RG_II      2'h2
`define BSA_RG_III     2'h3

// reset values
`define BSA_AC_RST     2'h0
`define BSA_T_RST      2'h0
`define BSA_MAR_RST    2'h0
`define BSA_MEM_RST    2'h0

`endif

/* File: bsa_pkg.sv */
/*
  types shared by the bit-slice alu design files.
  assumes bsa_cfg.svh is on the include path.
*/
`include "bsa_cfg.svh"

package bsa_pkg;

  typedef logic [`BSA_W-1:0]     bsa_word_type;
  typedef logic [`BSA_SEL_W-1:0] bsa_sel_type;

  typedef enum logic [1:0] {
    BSA_IDLE,
    BSA_EXEC
  } bsa_state_type;

endpackage : bsa_pkg

/* File: bsa_mem_if.sv */
/*
  carrier between the alu core and its scratch register memory.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ns

interface bsa_mem_if;
  import bsa_pkg::*;

  bsa_sel_type  rd_addr;
  bsa_word_type rd_data;
  logic         wr_en;
  bsa_sel_type  wr_addr;
  bsa_word_type wr_data;

  modport core (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
  modport mem  (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);

endinterface : bsa_mem_if

/* File: bsa_scratch_mem.sv */
/*
  scratch register file of the slice: ten words, one write port, one read port
  with registered read data.
  assumes addresses at or above the register count are never written; they read zero.
*/
`timescale 1ns/1ns
`include "bsa_cfg.svh"

module bsa_scratch_mem
  import bsa_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // memory port
  bsa_mem_if.mem    port
);

  bsa_word_type store [`BSA_NREG];
  bsa_word_type rd_data_reg;

  wire rd_in_range = (port.rd_addr < `BSA_SEL_W'(`BSA_NREG));
  wire wr_in_range = (port.wr_addr < `BSA_SEL_W'(`BSA_NREG));

  // array has no reset: contents are undefined until software-visible microcode writes them
  always_ff @(posedge mclk) begin
    if (port.wr_en && wr_in_range) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_reg <= `BSA_MEM_RST;
    end else begin
      rd_data_reg <= rd_in_range ? store[port.rd_addr] : `BSA_MEM_RST;
    end
  end

  assign port.rd_data = rd_data_reg;

endmodule : bsa_scratch_mem

/* File: bsa_alu_slice.sv */
/*
  bit-slice central processing element datapath: decodes function groups 0 to 5 and
  register groups I, II and III, applies the mask bus and updates the scratch
  registers, accumulator, temporary register and memory address register.
  assumes the microprogram controller and neighbouring slices run on mclk, so their
  signals need no synchroniser; each microinstruction takes two clock cycles.
*/
`timescale 1ns/1ns
`include "bsa_cfg.svh"

module bsa_alu_slice
  import bsa_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  // microinstruction handshake
  input  wire logic                 op_valid,
  output logic                      op_ready,
  output logic                      op_done,
  // microinstruction fields
  input  wire logic [`BSA_FG_W-1:0] f_group,
  input  wire logic [`BSA_RG_W-1:0] r_group,
  input  wire bsa_sel_type          reg_sel,
  input  wire bsa_word_type         k_bus,
  input  wire logic                 carry_input,
  // data buses
  input  wire bsa_word_type         m_bus,
  input  wire bsa_word_type         i_bus,
  // slice links
  input  wire logic                 left_shift_in,
  output logic                      right_shift_out,
  output logic                      carry_output,
  // register views
  output bsa_word_type              memory_address_reg,
  output bsa_word_type              primary_register,
  output bsa_word_type              temp_register
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // w-bit add of two words and a carry, carry out in the top bit
  function automatic logic [`BSA_W:0] add3(input bsa_word_type a, input bsa_word_type b, input logic c);
    add3 = {1'b0, a} + {1'b0, b} + {{`BSA_W{1'b0}}, c};
  endfunction : add3

  // top bit of the right shift: left input plus mask term
  function automatic logic left_shift_in_mix(input logic li, input bsa_word_type ikw, input bsa_word_type atw);
    left_shift_in_mix = li | (ikw[`BSA_W-1] & atw[`BSA_W-1]);
  endfunction : left_shift_in_mix

  ////////////////////////////////////////////////////////////////////////////////
  // state and latched microinstruction

  bsa_state_type           state_reg;
  logic [`BSA_FG_W-1:0]    fg_reg;
  logic [`BSA_RG_W-1:0]    rg_reg;
  bsa_sel_type             sel_reg;
  bsa_word_type            k_reg;
  logic                    ci_reg;
  bsa_word_type            m_reg;
  bsa_word_type            i_reg;
  logic                    li_reg;
  bsa_word_type            ac_reg;
  bsa_word_type            t_reg;
  bsa_word_type            mar_reg;
  logic                    co_reg;
  logic                    ro_reg;
  logic                    done_reg;

  bsa_mem_if mem_bus ();

  bsa_scratch_mem u_mem (
    .mclk    (mclk),
    .reset_n (reset_n),
    .port    (mem_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // operand selection

  wire          accept  = op_valid && (state_reg == BSA_IDLE);
  wire          exec    = (state_reg == BSA_EXEC);
  wire          sel_t   = (sel_reg == `BSA_SEL_T);
  wire          sel_ac  = (sel_reg == `BSA_SEL_AC);
  wire          sel_mem = !sel_t && !sel_ac;
  wire          rg_i    = (rg_reg == `BSA_RG_I);
  wire          rg_ii   = (rg_reg == `BSA_RG_II);
  wire          rg_iii  = (rg_reg == `BSA_RG_III);
  // scratch operand: register file word, temporary or accumulator
  wire bsa_word_type rn = sel_t ? t_reg : (sel_ac ? ac_reg : mem_bus.rd_data);
  // target of groups II and III: low selector bit picks T over AC
  wire          at_is_t = sel_reg[0];
  wire bsa_word_type at = at_is_t ? t_reg : ac_reg;
  wire bsa_word_type ak = ac_reg & k_reg;
  wire bsa_word_type ik = i_reg & k_reg;

  // read address is taken straight from the bus on accept so data is ready in exec
  assign mem_bus.rd_addr = reg_sel;
  assign op_ready        = (state_reg == BSA_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // function decode

  logic [`BSA_W:0] sum;
  bsa_word_type    res;
  logic            wr_rn;
  logic            wr_ac_too;
  logic            wr_at;
  logic            mar_wr;
  bsa_word_type    mar_val;
  logic            co_next;
  logic            ro_next;

  always_comb begin
    sum       = '0;
    res       = '0;
    wr_rn     = 1'b0;
    wr_ac_too = 1'b0;
    wr_at     = 1'b0;
    mar_wr    = 1'b0;
    mar_val   = '0;
    co_next   = ci_reg;
    ro_next   = ro_reg;
    case (fg_reg)
      `BSA_FG_0: begin
        if (rg_i) begin
          sum       = add3(rn, ak, ci_reg);
          res       = sum[`BSA_W-1:0];
          co_next   = sum[`BSA_W];
          wr_rn     = 1'b1;
          wr_ac_too = 1'b1;
        end else if (rg_ii) begin
          sum     = add3(m_reg, ak, ci_reg);
          res     = sum[`BSA_W-1:0];
          co_next = sum[`BSA_W];
          wr_at   = 1'b1;
        end else if (rg_iii) begin
          // mask terms merge in; a zero mask gives the plain right shift
          ro_next = at[0] & ~ik[0];
          res     = {left_shift_in_mix(li_reg, ik, at), at[`BSA_W-1:1] | ik[`BSA_W-1:1]};
          res[0]  = res[0] | (at[0] & ik[0]);
          wr_at   = 1'b1;
        end
      end
      `BSA_FG_1: begin
        if (rg_i) begin
          mar_wr  = 1'b1;
          mar_val = k_reg | rn;
          sum     = add3(rn, k_reg, ci_reg);
          res     = sum[`BSA_W-1:0];
          co_next = sum[`BSA_W];
          wr_rn   = 1'b1;
        end else if (rg_ii) begin
          mar_wr  = 1'b1;
          mar_val = k_reg | m_reg;
          sum     = add3(m_reg, k_reg, ci_reg);
          res     = sum[`BSA_W-1:0];
          co_next = sum[`BSA_W];
          wr_at   = 1'b1;
        end else if (rg_iii) begin
          sum     = add3(~at | k_reg, at & k_reg, ci_reg);
          res     = sum[`BSA_W-1:0];
          co_next = sum[`BSA_W];
          wr_at   = 1'b1;
        end
      end
      `BSA_FG_2: begin
        // adding all ones is the minus one; zero mask leaves carry in minus one
        sum     = add3(rg_iii ? ik : ak, '1, ci_reg);
        res     = sum[`BSA_W-1:0];
        co_next = sum[`BSA_W];
        wr_rn   = rg_i;
        wr_at   = !rg_i;
      end
      `BSA_FG_3: begin
        if (rg_i) begin
          sum   = add3(rn, ak, ci_reg);
          wr_rn = 1'b1;
        end else if (rg_ii) begin
          sum   = add3(m_reg, ak, ci_reg);
          wr_at = 1'b1;
        end else if (rg_iii) begin
          sum   = add3(at, ik, ci_reg);
          wr_at = 1'b1;
        end
        res     = sum[`BSA_W-1:0];
        co_next = sum[`BSA_W];
      end
      `BSA_FG_4: begin
        if (rg_i) begin
          res   = rn & ak;
          wr_rn = 1'b1;
        end else if (rg_ii) begin
          res   = m_reg & ak;
          wr_at = 1'b1;
        end else if (rg_iii) begin
          res   = at & ik;
          wr_at = 1'b1;
        end
        co_next = ci_reg | (|res);
      end
      `BSA_FG_5: begin
        if (rg_i) begin
          res   = k_reg & rn;
          wr_rn = 1'b1;
        end else if (rg_ii) begin
          res   = k_reg & m_reg;
          wr_at = 1'b1;
        end else if (rg_iii) begin
          res   = k_reg & at;
          wr_at = 1'b1;
        end
        co_next = ci_reg | (|res);
      end
      default: begin
        // groups 6 and 7 are not built here: no write, carry passes through
        co_next = ci_reg;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write-back steering

  wire rn_to_ac = exec && ((wr_rn && sel_ac) || wr_ac_too || (wr_at && !at_is_t));
  wire rn_to_t  = exec && ((wr_rn && sel_t) || (wr_at && at_is_t));

  assign mem_bus.wr_en   = exec && wr_rn && sel_mem;
  assign mem_bus.wr_addr = sel_reg;
  assign mem_bus.wr_data = res;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing and microinstruction capture

  // fields are captured on accept, so the controller only needs them in that cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= BSA_IDLE;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= exec;
      case (state_reg)
        BSA_IDLE: begin
          if (op_valid) begin
            state_reg <= BSA_EXEC;
          end
        end
        BSA_EXEC: begin
          state_reg <= BSA_IDLE;
        end
        default: begin
          state_reg <= BSA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fg_reg  <= `BSA_FG_0;
      rg_reg  <= `BSA_RG_I;
      sel_reg <= `BSA_SEL_AC;
      k_reg   <= '0;
      ci_reg  <= 1'b0;
      m_reg   <= '0;
      i_reg   <= '0;
      li_reg  <= 1'b0;
    end else if (accept) begin
      fg_reg  <= f_group;
      rg_reg  <= r_group;
      sel_reg <= reg_sel;
      k_reg   <= k_bus;
      ci_reg  <= carry_input;
      m_reg   <= m_bus;
      i_reg   <= i_bus;
      li_reg  <= left_shift_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // datapath registers

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ac_reg  <= `BSA_AC_RST;
      t_reg   <= `BSA_T_RST;
      mar_reg <= `BSA_MAR_RST;
      co_reg  <= 1'b0;
      ro_reg  <= 1'b0;
    end else if (exec) begin
      if (rn_to_ac) begin
        ac_reg <= res;
      end
      if (rn_to_t) begin
        t_reg <= res;
      end
      if (mar_wr) begin
        mar_reg <= mar_val;
      end
      co_reg <= co_next;
      ro_reg <= ro_next;
    end
  end

  assign op_done            = done_reg;
  assign carry_output       = co_reg;
  assign right_shift_out    = ro_reg;
  assign memory_address_reg = mar_reg;
  assign primary_register   = ac_reg;
  assign temp_register      = t_reg;

endmodule : bsa_alu_slice

/* File: bsa_alu_slice_properties.sv */
/*
  concurrent checks on the ports of the bit-slice alu top module, bound into every instance.
  assumes one clock domain and that fields are sampled at the accepting edge only.
*/
`timescale 1ns/1ns
`include "bsa_cfg.svh"

module bsa_alu_slice_props
  import bsa_pkg::*;
(
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 reset_n,
  // handshake
  input wire logic                 op_valid,
  input wire logic                 op_ready,
  input wire logic                 op_done,
  // microinstruction fields
  input wire logic [`BSA_FG_W-1:0] f_group,
  input wire logic [`BSA_RG_W-1:0] r_group,
  input wire bsa_sel_type          reg_sel,
  input wire bsa_word_type         k_bus,
  input wire logic                 carry_input,
  // buses and links
  input wire bsa_word_type         m_bus,
  input wire bsa_word_type         i_bus,
  input wire logic                 left_shift_in,
  input wire logic                 right_shift_out,
  input wire logic                 carry_output,
  // register views
  input wire bsa_word_type         memory_address_reg,
  input wire bsa_word_type         primary_register,
  input wire bsa_word_type         temp_register
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_accept;
    op_valid && op_ready;
  endsequence
  sequence s_shift_ac;
    s_accept ##0 (f_group == `BSA_FG_0 && r_group == `BSA_RG_III && k_bus == 2'h0 && !reg_sel[0]);
  endsequence
  sequence s_and_mem;
    s_accept ##0 (f_group == `BSA_FG_4 && r_group == `BSA_RG_II);
  endsequence

  chk_done_timing: assert property (s_accept |=> !op_ready && !op_done ##1 op_done && op_ready)
    else $error("op_done not two edges after accept");
  chk_done_single: assert property (op_done |=> !op_done)
    else $error("op_done longer than one cycle");
  chk_done_cause: assert property (op_done |-> $past(op_valid && op_ready, 2))
    else $error("op_done without an accepted microinstruction");
  chk_regs_exec: assert property ($changed(primary_register) || $changed(temp_register) |-> op_done)
    else $error("target register changed outside an execute edge");
  chk_mar_group1: assert property ($changed(memory_address_reg) |-> op_done && $past(f_group, 2) == `BSA_FG_1
      && $past(r_group, 2) inside {`BSA_RG_I, `BSA_RG_II})
    else $error("address register changed outside group 1");
  chk_ro_source: assert property ($changed(right_shift_out) |-> $past(f_group, 2) == `BSA_FG_0
      && $past(r_group, 2) == `BSA_RG_III)
    else $error("right shift output changed outside a shift");
  chk_shift_right: assert property (s_shift_ac |-> ##2 right_shift_out == $past(primary_register[0], 2)
      && primary_register == {$past(left_shift_in, 2), $past(primary_register[1], 2)})
    else $error("right shift result wrong");
  chk_clear_set: assert property (s_accept ##0 (f_group == `BSA_FG_2 && r_group == `BSA_RG_II && k_bus == 2'h0
      && !reg_sel[0]) |-> ##2 primary_register == ($past(carry_input, 2) ? 2'h0 : 2'h3))
    else $error("clear or set result wrong");
  chk_and_carry: assert property (s_and_mem |-> ##2 carry_output == ($past(carry_input, 2)
      | (|($past(m_bus, 2) & $past(primary_register, 2) & $past(k_bus, 2)))))
    else $error("and carry output wrong");
  chk_zero_mask_co: assert property (s_accept ##0 (f_group inside {`BSA_FG_4, `BSA_FG_5} && k_bus == 2'h0)
      |-> ##2 carry_output == $past(carry_input, 2))
    else $error("carry output does not follow carry input");
  chk_test_mem: assert property (s_accept ##0 (f_group == `BSA_FG_5 && r_group == `BSA_RG_II && k_bus == 2'h3)
      |-> ##2 carry_output == ($past(carry_input, 2) | (|$past(m_bus, 2))))
    else $error("memory test carry wrong");
endmodule : bsa_alu_slice_props

bind bsa_alu_slice bsa_alu_slice_props i_props (.mclk(mclk), .reset_n(reset_n), .op_valid(op_valid),
  .op_ready(op_ready), .op_done(op_done), .f_group(f_group), .r_group(r_group), .reg_sel(reg_sel),
  .k_bus(k_bus), .carry_input(carry_input), .m_bus(m_bus), .i_bus(i_bus), .left_shift_in(left_shift_in),
  .right_shift_out(right_shift_out), .carry_output(carry_output), .memory_address_reg(memory_address_reg),
  .primary_register(primary_register), .temp_register(temp_register));

/* File: bsa_uctl_model.sv */
/*
  microprogram controller and neighbour slices as seen by the alu: offers one microinstruction.
  assumes issue is called at a falling edge of mclk.
*/
`timescale 1ns/1ns
`include "bsa_cfg.svh"

module bsa_uctl_model
  import bsa_pkg::*;
(
  // clock and handshake
  input  wire logic                 mclk,
  input  wire logic                 op_ready,
  input  wire logic                 op_done,
  // microinstruction and buses
  output logic                      op_valid,
  output logic [`BSA_FG_W-1:0]      f_group,
  output logic [`BSA_RG_W-1:0]      r_group,
  output bsa_sel_type               reg_sel,
  output bsa_word_type              k_bus,
  output logic                      carry_input,
  output bsa_word_type              m_bus,
  output bsa_word_type              i_bus,
  output logic                      left_shift_in
);
  initial begin
    {op_valid, f_group, r_group, reg_sel, k_bus, carry_input, m_bus, i_bus, left_shift_in} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // returns at the falling edge where op_done shows, ok low if it never came
  task automatic issue(input logic [2:0] fg, input logic [1:0] rg, input logic [3:0] sel,
      input logic [1:0] k, input logic ci, input logic [1:0] m, input logic [1:0] i, input logic li,
      output logic ok);
    int n;
    logic rdy;
    ok = 1'h0;
    rdy = 1'h0;
    {op_valid, f_group, r_group, reg_sel, k_bus, carry_input, m_bus, i_bus, left_shift_in} =
      {1'h1, fg, rg, sel, k, ci, m, i, li};
    for (n = 0; n < 8 && !rdy; n++) begin
      rdy = op_ready;
      @(posedge mclk);
    end
    @(negedge mclk);
    // released fields flip, so a late sample shows up as a wrong result
    op_valid = 1'h0;
    {f_group, r_group, reg_sel, k_bus, carry_input} = ~{f_group, r_group, reg_sel, k_bus, carry_input};
    {m_bus, i_bus, left_shift_in} = ~{m_bus, i_bus, left_shift_in};
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge mclk);
      ok = rdy & op_done;
    end
  endtask : issue
endmodule : bsa_uctl_model

/* File: bit_slice_alu_function_decode_test.sv */
/*
  self-checking bench for the bit-slice alu: a register model predicts every register result; carry is checked for groups 4, 5 and the shift only.
  assumes bsa_uctl_model offers the microinstructions; scratch words are written before use.
*/
`timescale 1ns/1ns
`include "bsa_cfg.svh"

module bit_slice_alu_function_decode_test;
  import bsa_pkg::*;
  logic                 mclk = 1'h0;
  logic                 reset_n = 1'h0;
  logic                 op_valid, op_ready, op_done, carry_input, left_shift_in;
  logic                 right_shift_out, carry_output;
  logic [`BSA_FG_W-1:0] f_group;
  logic [`BSA_RG_W-1:0] r_group;
  bsa_sel_type          reg_sel;
  bsa_word_type         k_bus, m_bus, i_bus, memory_address_reg, primary_register, temp_register;
  bsa_word_type         regs [0:11] = '{default: 2'h0};
  bsa_word_type         mar_e = 2'h0;
  logic                 ro_e = 1'h0;
  logic                 co_e = 1'h0;
  int                   num_errors = 0;
  int                   num_checks = 0;

  always #25 mclk = ~mclk;

  bsa_alu_slice i_dut (.mclk(mclk), .reset_n(reset_n), .op_valid(op_valid), .op_ready(op_ready),
    .op_done(op_done), .f_group(f_group), .r_group(r_group), .reg_sel(reg_sel), .k_bus(k_bus),
    .carry_input(carry_input), .m_bus(m_bus), .i_bus(i_bus), .left_shift_in(left_shift_in),
    .right_shift_out(right_shift_out), .carry_output(carry_output), .memory_address_reg(memory_address_reg),
    .primary_register(primary_register), .temp_register(temp_register));
  bsa_uctl_model i_ctl (.mclk(mclk), .op_ready(op_ready), .op_done(op_done), .op_valid(op_valid),
    .f_group(f_group), .r_group(r_group), .reg_sel(reg_sel), .k_bus(k_bus), .carry_input(carry_input),
    .m_bus(m_bus), .i_bus(i_bus), .left_shift_in(left_shift_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string name, input logic [1:0] exp, input logic [1:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  // index 10 models the temporary register, 11 the accumulator
  task automatic op(input logic [2:0] fg, input logic [1:0] rg, input logic [3:0] sel, input logic [1:0] k,
      input logic ci, input logic [1:0] m, input logic [1:0] i, input logic li);
    logic ok;
    int wi;
    bsa_word_type at, src, res;
    wi = (rg == 2'h1) ? int'(sel) : (sel[0] ? 10 : 11);
    at = regs[sel[0] ? 10 : 11];
    src = (rg == 2'h1) ? regs[sel] : (rg == 2'h2) ? m : at;
    i_ctl.issue(fg, rg, sel, k, ci, m, i, li, ok);
    case (fg)
      3'h0: res = (rg == 2'h3) ? {li, at[1]} : src + (regs[11] & k) + ci;
      3'h1: res = (rg == 2'h3) ? (~at | k) + (at & k) + ci : src + k + ci;
      3'h2: res = (((rg == 2'h3) ? i : regs[11]) & k) - 2'h1 + ci;
      3'h3: res = (rg == 2'h3) ? at + (i & k) + ci : src + (regs[11] & k) + ci;
      3'h4: res = src & ((rg == 2'h3) ? i : regs[11]) & k;
      default: res = src & k;
    endcase
    regs[wi] = res;
    if (fg == 3'h0 && rg == 2'h1) regs[11] = res;
    if (fg == 3'h1 && rg != 2'h3) mar_e = k | src;
    if (fg == 3'h0 && rg == 2'h3) ro_e = at[0];
    co_e = (fg > 3'h3) ? ci | (|res) : ci;
    cmp("op_done", 2'h1, {1'h0, ok});
    cmp("primary_register", regs[11], primary_register);
    cmp("temp_register", regs[10], temp_register);
    cmp("memory_address_reg", mar_e, memory_address_reg);
    cmp("right_shift_out", {1'h0, ro_e}, {1'h0, right_shift_out});
    if (fg > 3'h3 || (fg == 3'h0 && rg == 2'h3)) cmp("carry_output", {1'h0, co_e}, {1'h0, carry_output});
  endtask : op

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_init;
    for (int n = 0; n < 10; n++) begin
      op(3'h5, 2'h2, 4'h0, 2'h3, 1'h0, n[1:0], 2'h0, 1'h0);
      op(3'h2, 2'h1, n[3:0], 2'h3, 1'h1, 2'h0, 2'h0, 1'h0);
    end
    op(3'h5, 2'h2, 4'h1, 2'h3, 1'h1, 2'h2, 2'h0, 1'h0);
  endtask : t_init

  task automatic t_group0;
    op(3'h0, 2'h1, 4'h1, 2'h0, 1'h0, 2'h0, 2'h0, 1'h0);
    op(3'h0, 2'h1, 4'hb, 2'h3, 1'h0, 2'h0, 2'h0, 1'h0);
    op(3'h0, 2'h1, 4'h5, 2'h1, 1'h1, 2'h0, 2'h0, 1'h0);
    op(3'h0, 2'h1, 4'ha, 2'h2, 1'h0, 2'h0, 2'h0, 1'h0);
    for (int n = 0; n < 4; n++) begin
      op(3'h0, 2'h3, {3'h0, n[0]}, 2'h0, n[0], 2'h0, 2'h3, n[1]);
    end
  endtask : t_group0

  task automatic t_group1;
    for (int k = 0; k < 4; k++) begin
      op(3'h1, 2'h1, k[3:0] + 4'h2, k[1:0], k[0], 2'h0, 2'h0, 1'h0);
      op(3'h1, 2'h2, {3'h0, k[0]}, k[1:0], k[1], k[1:0] ^ 2'h1, 2'h0, 1'h0);
      op(3'h1, 2'h3, {3'h0, k[1]}, k[1:0], k[0], 2'h0, 2'h0, 1'h0);
    end
  endtask : t_group1

  task automatic t_group2;
    for (int n = 0; n < 8; n++) begin
      op(3'h2, 2'h1, n[3:1] + 4'h6, n[2:1], n[0], 2'h0, 2'h0, 1'h0);
      op(3'h2, 2'h2, 4'h0, n[2:1], n[0], 2'h0, 2'h0, 1'h0);
      op(3'h2, 2'h3, 4'h1, n[2:1], n[0], 2'h0, 2'h2, 1'h0);
    end
  endtask : t_group2

  task automatic t_group3;
    for (int k = 0; k < 4; k++) begin
      op(3'h3, 2'h1, k[3:0] + 4'h1, k[1:0], 1'h1, 2'h0, 2'h0, 1'h0);
      op(3'h3, 2'h2, {3'h0, k[0]}, k[1:0], 1'h0, 2'h3, 2'h0, 1'h0);
      op(3'h3, 2'h3, 4'h1, k[1:0], 1'h1, 2'h0, 2'h1, 1'h0);
    end
  endtask : t_group3

  task automatic t_group45;
    for (int n = 0; n < 24; n++) begin
      op(3'h5, 2'h2, 4'h0, 2'h3, 1'h0, 2'h3, 2'h0, 1'h0);
      op(3'h5, 2'h2, 4'h1, 2'h3, 1'h0, n[1:0] | 2'h1, 2'h0, 1'h0);
      op(3'h2, 2'h1, 4'h2 + n[1:0], 2'h3, 1'h1, 2'h0, 2'h0, 1'h0);
      op({2'h2, n[0] ^ n[4]}, 2'h1 + n[3:2] % 3, 4'h2 + n[1:0], n[1:0], n[2], n[1:0] ^ 2'h2, 2'h3, 1'h0);
    end
  endtask : t_group45

  task close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (6) @(negedge mclk);
    reset_n = 1'h1;
    @(negedge mclk);
    t_init;
    t_group0;
    t_group1;
    t_group2;
    t_group3;
    t_group45;
    close_out;
  end

  // under 200 microinstructions of two cycles each; the limit leaves wide margin
  initial begin
    #(5000 * 50);
    num_errors++;
    close_out;
  end
endmodule : bit_slice_alu_function_decode_test
